// ---- src/rt_device_end.sv ----
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
// How it works
// - 32 word registers; 2, 4, 6 and 10-15 unused, 16-31 table
// - All bits active high, clear on reset
// - Host reconfigures only while run bit clear; control writes are taken with run set too
// - Host stops within 5 us of active
// - Bit 15 starts; writing it clear stops
// - Address parity error blocks run, flags status
// - Bit 14 starts self test; stop first
// - Test and run together: test wins
// - Bit 13 soft reset, 5 us, full clear
// - Soft reset acts only after ready asserted
// - Bits 12/11 enable channels A/B
// - Bit 10 selects external tag clock
// - Bit 6 enables buffer mode
// - Bit 4 broadcast; else 31 is ordinary
// - Bit 3 allows dynamic bus control answer
// - Bit 2 ping-pong, clear means indexing
// - Bit 1 enables interrupt logging
// - Bit 0 auto status transmit in A mode
// - Auto status only with standard select set
module rt_device_end (
    input  wire logic         clk,
    input  wire logic         reset,
    rt_reg_link.device        link,
    input  wire logic [5:0]   terminal_address,
    input  wire logic         standard_select,
    input  wire logic         message_active,
    input  wire logic         self_test_done,
    output logic              run_enable,
    output logic              executing_flag,
    output logic              addr_parity_fail,
    output logic              self_test_request,
    output logic              soft_reset_request,
    output logic              channel_a_enable,
    output logic              channel_b_enable,
    output logic              ext_tag_clock_select,
    output logic              buffer_mode_enable,
    output logic              broadcast_enable,
    output logic              dyn_bus_ctrl_accept,
    output logic              double_buffer_enable,
    output logic              irq_log_enable,
    output logic              auto_status_transmit,
    output logic              std_1553a_mode
);
    typedef struct packed {
        logic [15:0] control;
        logic [15:0] irq_mask;
        logic [15:0] log_ptr;
        logic [15:0] time_tag;
        logic [15:0] desc_ptr;
        logic [15:0] status_bits;
        logic [15:0] rdata;
        logic        ack;
        logic        testing;
        logic        ready;
        logic [5:0]  addr_sync1;
        logic [5:0]  addr_sync2;
        logic [1:0]  std_sync;
        logic [1:0]  active_sync;
        logic [1:0]  done_sync;
    } dev_state_t;

    dev_state_t  s;
    dev_state_t  next_s;
    logic [15:0] table_mem [rt_ctrl_pkg::TABLE_N];
    logic        soft_busy;
    logic        soft_start;
    logic        parity_ok;
    logic        parity_bad;
    logic        write_hit;
    logic [15:0] status_word;

    function automatic logic is_table(input logic [4:0] a);
        return a[4];
    endfunction

    soft_reset_timer soft_reset_timer_i (
        .clk   (clk),
        .reset (reset),
        .start (soft_start),
        .busy  (soft_busy)
    );

    // Odd parity required over address and parity bit
    assign parity_bad = ~(^s.addr_sync2);
    assign parity_ok  = ~parity_bad;
    // Nothing is taken while a soft reset runs
    assign write_hit  = link.req & link.we & ~s.ack & ~soft_busy;
    // Soft reset honoured only once ready has been seen
    assign soft_start = write_hit && link.addr == rt_ctrl_pkg::ADDR_CONTROL
                        && link.wdata[rt_ctrl_pkg::B_SOFT_RESET] && s.ready;

    // Status mirrors pins and live flags; writes are ignored
    always_comb begin
        status_word = rt_ctrl_pkg::ZERO16;
        status_word[rt_ctrl_pkg::S_ADDR_HI:rt_ctrl_pkg::S_ADDR_LO] = s.addr_sync2;
        status_word[rt_ctrl_pkg::S_STD]    = s.std_sync[1];
        status_word[rt_ctrl_pkg::S_EXEC]   = executing_flag;
        status_word[rt_ctrl_pkg::S_PFAIL]  = parity_bad;
        status_word[rt_ctrl_pkg::S_READY]  = s.ready;
        status_word[rt_ctrl_pkg::S_ACTIVE] = s.active_sync[1];
    end

    always_comb begin
        next_s             = s;
        next_s.addr_sync1  = terminal_address;
        next_s.addr_sync2  = s.addr_sync1;
        next_s.std_sync    = {s.std_sync[0], standard_select};
        next_s.active_sync = {s.active_sync[0], message_active};
        next_s.done_sync   = {s.done_sync[0], self_test_done};
        next_s.ack         = link.req & ~s.ack & ~soft_busy;
        // Held requests wait out a soft reset, then get their ack
        if (soft_busy) begin
            next_s = '0;
        end else begin
            next_s.ready = 1'b1;
            if (s.testing && s.done_sync[1]) begin
                next_s.testing = 1'b0;
                next_s.control[rt_ctrl_pkg::B_TEST] = 1'b0;
            end
            if (write_hit && !soft_start) begin
                case (link.addr)
                    rt_ctrl_pkg::ADDR_CONTROL: begin
                        next_s.control = link.wdata & rt_ctrl_pkg::CONTROL_MASK;
                        next_s.control[rt_ctrl_pkg::B_SOFT_RESET] = 1'b0;
                        if (link.wdata[rt_ctrl_pkg::B_TEST]) begin
                            next_s.testing = 1'b1;
                            next_s.control[rt_ctrl_pkg::B_RUN] = 1'b0;
                        end
                    end
                    rt_ctrl_pkg::ADDR_IRQ_MASK:    next_s.irq_mask    = link.wdata;
                    rt_ctrl_pkg::ADDR_LOG_PTR:     next_s.log_ptr     = link.wdata;
                    rt_ctrl_pkg::ADDR_TIME_TAG:    next_s.time_tag    = link.wdata;
                    rt_ctrl_pkg::ADDR_DESC_PTR:    next_s.desc_ptr    = link.wdata;
                    rt_ctrl_pkg::ADDR_STATUS_BITS: next_s.status_bits = link.wdata;
                    default: begin
                    end
                endcase
            end
            // Read data latched at the edge the request is taken
            if (link.req && !s.ack) begin
                if (is_table(link.addr)) begin
                    next_s.rdata = table_mem[link.addr[3:0]];
                end else begin
                    case (link.addr)
                        rt_ctrl_pkg::ADDR_CONTROL:     next_s.rdata = s.control;
                        rt_ctrl_pkg::ADDR_STATUS:      next_s.rdata = status_word;
                        rt_ctrl_pkg::ADDR_IRQ_MASK:    next_s.rdata = s.irq_mask;
                        rt_ctrl_pkg::ADDR_LOG_PTR:     next_s.rdata = s.log_ptr;
                        rt_ctrl_pkg::ADDR_TIME_TAG:    next_s.rdata = s.time_tag;
                        rt_ctrl_pkg::ADDR_DESC_PTR:    next_s.rdata = s.desc_ptr;
                        rt_ctrl_pkg::ADDR_STATUS_BITS: next_s.rdata = s.status_bits;
                        default: begin
                            next_s.rdata = rt_ctrl_pkg::ZERO16;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Table lives outside the packed state; cleared by soft reset too
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < rt_ctrl_pkg::TABLE_N; i++) begin
                table_mem[i] <= rt_ctrl_pkg::ZERO16;
            end
        end else if (soft_busy) begin
            for (int i = 0; i < rt_ctrl_pkg::TABLE_N; i++) begin
                table_mem[i] <= rt_ctrl_pkg::ZERO16;
            end
        end else if (write_hit && is_table(link.addr)) begin
            table_mem[link.addr[3:0]] <= link.wdata;
        end
    end

    assign link.rdata           = s.rdata;
    assign link.ack             = s.ack;
    assign link.ready_out       = s.ready;
    assign link.terminal_active = s.active_sync[1] & executing_flag;

    // Control fields drive the datapath from the register; channels A/B and auto status are gated
    assign run_enable           = s.control[rt_ctrl_pkg::B_RUN];
    // Parity fault holds off executing_flag and both channels; run_enable still follows the control bit
    assign executing_flag       = run_enable & parity_ok;
    assign addr_parity_fail     = parity_bad;
    assign self_test_request    = s.testing;
    assign soft_reset_request   = soft_busy;
    assign channel_a_enable     = s.control[rt_ctrl_pkg::B_CHA] & parity_ok;
    assign channel_b_enable     = s.control[rt_ctrl_pkg::B_CHB] & parity_ok;
    assign ext_tag_clock_select = s.control[rt_ctrl_pkg::B_EXTCLK];
    assign buffer_mode_enable   = s.control[rt_ctrl_pkg::B_BUFMODE];
    assign broadcast_enable     = s.control[rt_ctrl_pkg::B_BCAST];
    assign dyn_bus_ctrl_accept  = s.control[rt_ctrl_pkg::B_DYN_CTRL];
    assign double_buffer_enable = s.control[rt_ctrl_pkg::B_PINGPONG];
    assign irq_log_enable       = s.control[rt_ctrl_pkg::B_IRQLOG];
    assign std_1553a_mode       = s.std_sync[1];
    assign auto_status_transmit = s.control[rt_ctrl_pkg::B_AUTOSTAT]
                                  & s.std_sync[1];
endmodule

// ---- src/rt_ctrl_pkg.sv ----
package rt_ctrl_pkg;
    localparam int unsigned CLK_MHZ         = 50;
    localparam int unsigned SOFT_RESET_US   = 5;
    localparam int unsigned SOFT_RESET_CYC  = SOFT_RESET_US * CLK_MHZ;
    localparam int unsigned STOP_WINDOW_US  = 5;
    localparam int unsigned STOP_WINDOW_CYC = STOP_WINDOW_US * CLK_MHZ;

    localparam int unsigned REG_AW   = 5;
    localparam int unsigned REG_DW   = 16;
    localparam int unsigned TABLE_N  = 16;

    localparam logic [4:0] ADDR_CONTROL     = 5'h00;
    localparam logic [4:0] ADDR_STATUS      = 5'h01;
    localparam logic [4:0] ADDR_COMMAND     = 5'h02;
    localparam logic [4:0] ADDR_IRQ_MASK    = 5'h03;
    localparam logic [4:0] ADDR_IRQ_PEND    = 5'h04;
    localparam logic [4:0] ADDR_LOG_PTR     = 5'h05;
    localparam logic [4:0] ADDR_SELF_TEST   = 5'h06;
    localparam logic [4:0] ADDR_TIME_TAG    = 5'h07;
    localparam logic [4:0] ADDR_DESC_PTR    = 5'h08;
    localparam logic [4:0] ADDR_STATUS_BITS = 5'h09;
    localparam logic [4:0] ADDR_TABLE_BASE  = 5'h10;

    localparam int unsigned B_RUN      = 15;
    localparam int unsigned B_TEST     = 14;
    localparam int unsigned B_SOFT_RESET = 13;
    localparam int unsigned B_CHA      = 12;
    localparam int unsigned B_CHB      = 11;
    localparam int unsigned B_EXTCLK   = 10;
    localparam int unsigned B_BUFMODE  = 6;
    localparam int unsigned B_BCAST    = 4;
    localparam int unsigned B_DYN_CTRL = 3;
    localparam int unsigned B_PINGPONG = 2;
    localparam int unsigned B_IRQLOG   = 1;
    localparam int unsigned B_AUTOSTAT = 0;

    localparam logic [15:0] CONTROL_MASK = 16'hFC5F;
    localparam logic [15:0] ZERO16       = 16'h0000;

    localparam int unsigned S_ADDR_HI = 15;
    localparam int unsigned S_ADDR_LO = 10;
    localparam int unsigned S_STD     = 7;
    localparam int unsigned S_EXEC    = 3;
    localparam int unsigned S_PFAIL   = 2;
    localparam int unsigned S_READY   = 1;
    localparam int unsigned S_ACTIVE  = 0;

    // Host command port register offsets (byte addresses)
    localparam logic [3:0] H_ADDR   = 4'h0;
    localparam logic [3:0] H_WDATA  = 4'h4;
    localparam logic [3:0] H_GO     = 4'h8;
    localparam logic [3:0] H_RESULT = 4'hC;
    localparam int unsigned H_GO_WRITE = 0;
    localparam int unsigned H_BUSY     = 16;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_REQ  = 2'b01,
        HS_DONE = 2'b11
    } host_state_t;
endpackage

// ---- src/rt_reg_link.sv ----
`timescale 1ns/10ps
interface rt_reg_link;
    logic        req;
    logic        we;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;
    logic        terminal_active;
    logic        ready_out;

    modport device (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        output rdata,
        output ack,
        output terminal_active,
        output ready_out
    );
    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input  rdata,
        input  ack,
        input  terminal_active,
        input  ready_out
    );
endinterface

// ---- src/soft_reset_timer.sv ----
`timescale 1ns/10ps
module soft_reset_timer (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      busy
);
    typedef struct packed {
        logic [8:0] count;
        logic       busy;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    always_comb begin
        next_s = s;
        if (s.busy) begin
            if (s.count == 9'(rt_ctrl_pkg::SOFT_RESET_CYC - 1)) begin
                next_s.busy  = 1'b0;
                next_s.count = 9'h000;
            end else begin
                next_s.count = s.count + 9'h001;
            end
        end else if (start) begin
            next_s.busy = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
endmodule

// ---- src/rt_host_end.sv ----
`timescale 1ns/10ps
module rt_host_end (
    input  wire logic         clk,
    input  wire logic         reset,
    rt_reg_link.host          link,
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest
);
    typedef struct packed {
        rt_ctrl_pkg::host_state_t st;
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic [15:0] result;
        logic [31:0] rdata;
        logic        resp;
    } host_reg_t;

    host_reg_t s;
    host_reg_t next_s;

    always_comb begin
        next_s      = s;
        next_s.resp = (avs_read | avs_write) & ~s.resp;
        if ((avs_read || avs_write) && !s.resp) begin
            if (avs_write) begin
                case (avs_address)
                    rt_ctrl_pkg::H_ADDR:  next_s.addr  = avs_writedata[4:0];
                    rt_ctrl_pkg::H_WDATA: next_s.wdata = avs_writedata[15:0];
                    rt_ctrl_pkg::H_GO: begin
                        if (s.st != rt_ctrl_pkg::HS_REQ) begin
                            next_s.we = avs_writedata[rt_ctrl_pkg::H_GO_WRITE];
                            next_s.st = rt_ctrl_pkg::HS_REQ;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                next_s.rdata = 32'h00000000;
                case (avs_address)
                    rt_ctrl_pkg::H_ADDR:  next_s.rdata[4:0]  = s.addr;
                    rt_ctrl_pkg::H_WDATA: next_s.rdata[15:0] = s.wdata;
                    rt_ctrl_pkg::H_RESULT: begin
                        next_s.rdata[15:0] = s.result;
                        next_s.rdata[rt_ctrl_pkg::H_BUSY] = (s.st == rt_ctrl_pkg::HS_REQ);
                    end
                    default: begin
                    end
                endcase
            end
        end
        case (s.st)
            rt_ctrl_pkg::HS_IDLE: begin
            end
            rt_ctrl_pkg::HS_REQ: begin
                if (link.ack) begin
                    next_s.result = link.rdata;
                    next_s.st     = rt_ctrl_pkg::HS_DONE;
                end
            end
            rt_ctrl_pkg::HS_DONE: begin
            end
            default: next_s.st = rt_ctrl_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.req        = (s.st == rt_ctrl_pkg::HS_REQ);
    assign link.we         = s.we;
    assign link.addr       = s.addr;
    assign link.wdata      = s.wdata;
    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~s.resp;
endmodule

// ---- bench/rt_link_sva.sv ----
`timescale 1ns/10ps
module rt_link_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        req,
    input wire logic        we,
    input wire logic [4:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack,
    input wire logic        terminal_active,
    input wire logic        ready_out
);
    logic [8:0] low_cnt;

    // Cycles spent with ready low since last high
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_cnt <= 9'h000;
        end else if (ready_out) begin
            low_cnt <= 9'h000;
        end else begin
            low_cnt <= low_cnt + 9'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ($rose(ack) |-> $past(req))
        else $error("ack without request");
    a_ack_timely: assert property (req && !ack && ready_out |=> ack)
        else $error("request not answered next cycle");
    a_req_drop: assert property (ack |=> !req)
        else $error("request kept after ack");
    a_rdata_hold: assert property (!ack && ready_out && $past(ready_out)
        |-> $stable(rdata)) else $error("read data changed without ack");
    a_unused_zero: assert property (req && !we && !ack && ready_out && addr >= 5'h0A
        && addr <= 5'h0F |=> rdata == 16'h0000) else $error("unused address read nonzero");
    a_soft_start: assert property (req && we && !ack && ready_out && addr == 5'h00
        && wdata[13] |-> ##[1:3] !ready_out) else $error("soft reset did not start");
    a_soft_noack: assert property (!ready_out && !$past(ready_out) |-> !ack)
        else $error("ack during soft reset");
    a_soft_length: assert property ($rose(ready_out)
        |-> low_cnt < 9'h003 || low_cnt > 9'h0F5) else $error("soft reset length wrong");
    a_active_ready: assert property (terminal_active |-> ready_out)
        else $error("terminal active while not ready");
endmodule

// ---- bench/rt_control_register_bank_bench.sv ----
`timescale 1ns/10ps
module rt_control_register_bank_bench;
    logic        clk;
    logic        reset;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  terminal_address;
    logic        standard_select;
    logic        message_active;
    logic        self_test_done;
    logic        run_enable, executing_flag, addr_parity_fail, self_test_request;
    logic        soft_reset_request, channel_a_enable, channel_b_enable, ext_tag_clock_select;
    logic        buffer_mode_enable, broadcast_enable, dyn_bus_ctrl_accept;
    logic        double_buffer_enable, irq_log_enable, auto_status_transmit, std_1553a_mode;
    logic [15:0] cfg_bits;
    logic [15:0] q;
    int          num_errors;
    int          n_checks;

    assign cfg_bits = {8'h00, channel_a_enable, channel_b_enable, ext_tag_clock_select,
        buffer_mode_enable, broadcast_enable, dyn_bus_ctrl_accept, double_buffer_enable,
        irq_log_enable};

    rt_reg_link link ();
    rt_device_end rt_device_end_i (.clk(clk), .reset(reset), .link(link),
        .terminal_address(terminal_address), .standard_select(standard_select),
        .message_active(message_active), .self_test_done(self_test_done),
        .run_enable(run_enable), .executing_flag(executing_flag),
        .addr_parity_fail(addr_parity_fail), .self_test_request(self_test_request),
        .soft_reset_request(soft_reset_request), .channel_a_enable(channel_a_enable),
        .channel_b_enable(channel_b_enable), .ext_tag_clock_select(ext_tag_clock_select),
        .buffer_mode_enable(buffer_mode_enable), .broadcast_enable(broadcast_enable),
        .dyn_bus_ctrl_accept(dyn_bus_ctrl_accept), .double_buffer_enable(double_buffer_enable),
        .irq_log_enable(irq_log_enable), .auto_status_transmit(auto_status_transmit),
        .std_1553a_mode(std_1553a_mode));
    rt_host_end rt_host_end_i (.clk(clk), .reset(reset), .link(link),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    rt_link_sva rt_link_sva_i (.clk(clk), .reset(reset), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .terminal_active(link.terminal_active), .ready_out(link.ready_out));

    always #10 clk = ~clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stall(input string what);
        num_errors++;
        $display("unexpected %s: timed out", what);
        give_verdict();
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) stall("waitrequest");
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic reg_op(input logic wr, input logic [4:0] a, input logic [15:0] d,
                          output logic [15:0] rd);
        logic [31:0] r;
        int n;
        av_xfer(1'b1, rt_ctrl_pkg::H_ADDR, {27'h0000000, a}, r);
        av_xfer(1'b1, rt_ctrl_pkg::H_WDATA, {16'h0000, d}, r);
        av_xfer(1'b1, rt_ctrl_pkg::H_GO, {31'h00000000, wr}, r);
        n = 0;
        do begin
            av_xfer(1'b0, rt_ctrl_pkg::H_RESULT, 32'h00000000, r);
            n++;
        end while (r[rt_ctrl_pkg::H_BUSY] !== 1'b0 && n < 200);
        if (r[rt_ctrl_pkg::H_BUSY] !== 1'b0) stall("link busy");
        rd = r[15:0];
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] rd;
        reg_op(1'b1, a, d, rd);
    endtask

    task automatic expect_reg(input string what, input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] rd;
        reg_op(1'b0, a, 16'h0000, rd);
        check(what, rd, exp);
    endtask

    // Registers that keep written data; the rest read zero
    function automatic logic [15:0] map_exp(input int i);
        if (i == 2 || i == 4 || i == 6 || (i >= 10 && i < 16)) return 16'h0000;
        return {8'hA5, 8'(i)};
    endfunction

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        terminal_address = 6'h01;
        {standard_select, message_active, self_test_done} = 3'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 32; i++) begin
            if (i != 1) expect_reg("reset value", 5'(i), 16'h0000);
        end
        for (int i = 2; i < 32; i++) wr_reg(5'(i), {8'hA5, 8'(i)});
        for (int i = 2; i < 32; i++) begin
            expect_reg("register map", 5'(i), map_exp(i));
        end
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h1C7F);
        expect_reg("control", rt_ctrl_pkg::ADDR_CONTROL, 16'h1C5F);
        check("channel config", {14'h0000, cfg_bits[7:6]}, 16'h0003);
        check("features", cfg_bits, 16'h00FF);
        check("auto status in B mode", {15'h0000, auto_status_transmit}, 16'h0000);
        @(posedge clk);
        standard_select <= 1'b1;
        repeat (4) @(posedge clk);
        check("auto status in A mode", {15'h0000, auto_status_transmit}, 16'h0001);
        check("standard mirror", {15'h0000, std_1553a_mode}, 16'h0001);
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h0000);
        check("config cleared", cfg_bits, 16'h0000);
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h8000);
        check("run and executing", {14'h0000, run_enable, executing_flag}, 16'h0003);
        message_active <= 1'b1;
        repeat (4) @(posedge clk);
        check("terminal active", {15'h0000, link.terminal_active}, 16'h0001);
        message_active <= 1'b0;
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h0000);
        check("stopped", {14'h0000, run_enable, executing_flag}, 16'h0000);
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'hC000);
        check("test over run", {15'h0000, run_enable}, 16'h0000);
        check("test requested", {15'h0000, self_test_request}, 16'h0001);
        expect_reg("control in test", rt_ctrl_pkg::ADDR_CONTROL, 16'h4000);
        self_test_done <= 1'b1;
        repeat (4) @(posedge clk);
        check("test finished", {15'h0000, self_test_request}, 16'h0000);
        self_test_done <= 1'b0;
        terminal_address <= 6'h00;
        repeat (4) @(posedge clk);
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h9800);
        check("parity block", {12'h000, executing_flag, addr_parity_fail,
            channel_a_enable, channel_b_enable}, 16'h0004);
        reg_op(1'b0, rt_ctrl_pkg::ADDR_STATUS, 16'h0000, q);
        check("status flags", {14'h0000, q[3:2]}, 16'h0001);
        check("status pins", {8'h00, q[15:10], q[7], q[1]}, 16'h0003);
        terminal_address <= 6'h01;
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h0000);
        wr_reg(rt_ctrl_pkg::ADDR_CONTROL, 16'h2000);
        check("soft reset running", {15'h0000, soft_reset_request}, 16'h0001);
        for (int n = 0; n < 400 && link.ready_out !== 1'b1; n++) @(posedge clk);
        if (link.ready_out !== 1'b1) stall("ready after soft reset");
        expect_reg("table after soft reset", 5'h10, 16'h0000);
        expect_reg("mask after soft reset", rt_ctrl_pkg::ADDR_IRQ_MASK, 16'h0000);
        give_verdict();
    end
endmodule
